// ==== design/host_control_serial_port.sv ====
// host control serial port: serial register access, reset ready, line reset, interrupts
// assumes the host clocks bits on SCLK far slower than sys_clk_in (at least 4 cycles a phase)
// Operation
// RULE1: low reset input returns device to defaults
// RULE2: host holds reset low at least 300 ns
// RULE3: registers usable 5 ms after reset release
// RULE4: address 0x00 bit 7 shows reset ready
// RULE5: active-low reset output drives attached transceiver
// RULE6: high priority interrupt pulls low on status
// RULE7: low priority interrupt pulls low on status
// RULE8: interrupt outputs only pull low, never high
// RULE9: host supplies the serial clock for transfers
// RULE10: host sends command, address, then write data
// RULE11: read data returned serially on output line
// RULE12: active-low select qualifies accesses, idles high
// RULE13: deselect abandons partial access, ignores clock
// RULE14: interrupt holds until enabled pending causes cleared
`timescale 1ns/1ps
module host_control_serial_port
  import hcsp_pkg::*;
#(
  parameter int unsigned READY_CYCLES = RESET_READY_CYCLES,
  parameter int unsigned EVT_W        = 8
) (
  // clock, reset, enable
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clk_en_in,
  // serial microport pins
  input  wire logic             sclk_in,
  input  wire logic             si_in,
  input  wire logic             cs_n_in,
  output logic                  so_out,
  // status change events from the device core
  input  wire logic [EVT_W-1:0] evt_hi_in,
  input  wire logic [EVT_W-1:0] evt_lo_in,
  // transceiver reset and open-drain interrupts
  output logic                  line_transceiver_reset_out_n,
  output logic                  irq_hi_out,
  output logic                  irq_hi_oe_out,
  output logic                  irq_lo_out,
  output logic                  irq_lo_oe_out
);
  localparam int unsigned RDY_W = $clog2(READY_CYCLES + 1);

  pin_sync_if pins ();

  pin_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .sclk_in    (sclk_in),
    .si_in      (si_in),
    .cs_n_in    (cs_n_in),
    .pins       (pins)
  );

  // frame group
  frame_st_t          st_q,      st_d;
  logic [3:0]         cnt_q,     cnt_d;
  logic [7:0]         shreg_q,   shreg_d;
  logic [7:0]         tx_q,      tx_d;
  logic               rd_q,      rd_d;
  logic [ADDR_W-1:0]  addr_q,    addr_d;
  logic               sclk_p_q,  sclk_p_d;
  logic               so_q,      so_d;
  logic               wr_stb;
  logic [7:0]         wr_data;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               hdr_done;
  // register group
  logic               ready_q,   ready_d;
  logic [RDY_W-1:0]   rdy_cnt_q, rdy_cnt_d;
  logic               phy_ctl_q, phy_ctl_d;
  logic [EVT_W-1:0]   pend_hi_q, pend_hi_d;
  logic [EVT_W-1:0]   pend_lo_q, pend_lo_d;
  logic [EVT_W-1:0]   en_hi_q,   en_hi_d;
  logic [EVT_W-1:0]   en_lo_q,   en_lo_d;
  logic               phy_n_q,   phy_n_d;
  logic               ihi_oe_q,  ihi_oe_d;
  logic               ilo_oe_q,  ilo_oe_d;
  logic [7:0]         rd_data;

  assign sclk_rise = pins.sclk & ~sclk_p_q;
  assign sclk_fall = ~pins.sclk & sclk_p_q;
  assign hdr_done  = (st_q == ST_HDR) && sclk_rise && !pins.cs_n && (cnt_q == 4'(HDR_BITS - 1));

  always_comb begin
    rd_data = REG_RESET;
    case ({shreg_q[ADDR_W-2:0], pins.si})
      ADDR_RESET_READY_STATUS: begin
        rd_data[READY_BIT]   = ready_q; // RULE4
        rd_data[PHY_RST_BIT] = phy_ctl_q;
      end
      ADDR_IRQ_HI_PEND: rd_data = 8'(pend_hi_q);
      ADDR_IRQ_HI_EN:   rd_data = 8'(en_hi_q);
      ADDR_IRQ_LO_PEND: rd_data = 8'(pend_lo_q);
      ADDR_IRQ_LO_EN:   rd_data = 8'(en_lo_q);
      default:          rd_data = REG_RESET;
    endcase
  end

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    shreg_d  = shreg_q;
    tx_d     = tx_q;
    rd_d     = rd_q;
    addr_d   = addr_q;
    so_d     = so_q;
    sclk_p_d = pins.sclk;
    wr_stb   = 1'b0;
    wr_data  = {shreg_q[6:0], pins.si};
    if (pins.cs_n) begin
      // deselect drops any partial frame and ignores the serial clock
      st_d  = ST_IDLE; // RULE12 RULE13
      cnt_d = 4'h0;
      so_d  = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          st_d    = ST_HDR;
          cnt_d   = 4'h0;
          shreg_d = 8'h00;
        end
        ST_HDR: begin
          if (sclk_rise) begin
            shreg_d = wr_data; // RULE10
            cnt_d   = cnt_q + 4'h1;
            if (hdr_done) begin
              st_d   = ST_DATA;
              cnt_d  = 4'h0;
              rd_d   = (shreg_q[ADDR_W-1] == CMD_READ);
              addr_d = {shreg_q[ADDR_W-2:0], pins.si};
              tx_d   = rd_data;
            end
          end
        end
        ST_DATA: begin
          if (sclk_fall && rd_q) begin
            so_d = tx_q[7]; // RULE11
            tx_d = {tx_q[6:0], 1'b0};
          end
          if (sclk_rise) begin
            shreg_d = wr_data;
            cnt_d   = cnt_q + 4'h1;
            if (cnt_q == 4'(DATA_W - 1)) begin
              st_d   = ST_DONE;
              wr_stb = !rd_q;
            end
          end
        end
        ST_DONE: begin
          // extra clocks after a whole frame are ignored until deselect
          st_d = ST_DONE;
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 4'h0;
      shreg_q  <= 8'h00;
      tx_q     <= 8'h00;
      rd_q     <= 1'b0;
      addr_q   <= 7'h00;
      so_q     <= 1'b0;
      sclk_p_q <= 1'b0;
    end else if (clk_en_in) begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      shreg_q  <= shreg_d;
      tx_q     <= tx_d;
      rd_q     <= rd_d;
      addr_q   <= addr_d;
      so_q     <= so_d;
      sclk_p_q <= sclk_p_d;
    end
  end

  always_comb begin
    logic [EVT_W-1:0] clr_hi;
    logic [EVT_W-1:0] clr_lo;
    clr_hi    = '0;
    clr_lo    = '0;
    ready_d   = ready_q;
    rdy_cnt_d = rdy_cnt_q;
    phy_ctl_d = phy_ctl_q;
    en_hi_d   = en_hi_q;
    en_lo_d   = en_lo_q;
    // accesses before ready are not refused; the host is expected to poll first
    if (!ready_q) begin
      if (rdy_cnt_q == RDY_W'(READY_CYCLES - 1)) begin
        ready_d = 1'b1; // RULE3
      end else begin
        rdy_cnt_d = rdy_cnt_q + RDY_W'(1);
      end
    end
    if (wr_stb) begin
      case (addr_q)
        ADDR_RESET_READY_STATUS: phy_ctl_d = wr_data[PHY_RST_BIT];
        ADDR_IRQ_HI_PEND:        clr_hi    = EVT_W'(wr_data);
        ADDR_IRQ_HI_EN:          en_hi_d   = EVT_W'(wr_data);
        ADDR_IRQ_LO_PEND:        clr_lo    = EVT_W'(wr_data);
        ADDR_IRQ_LO_EN:          en_lo_d   = EVT_W'(wr_data);
        default:                 phy_ctl_d = phy_ctl_q;
      endcase
    end
    // a new event beats a write-one-to-clear in the same cycle
    pend_hi_d = (pend_hi_q & ~clr_hi) | evt_hi_in;
    pend_lo_d = (pend_lo_q & ~clr_lo) | evt_lo_in;
    phy_n_d   = ready_q & ~phy_ctl_q; // RULE5
    ihi_oe_d  = |(pend_hi_q & en_hi_q); // RULE6 RULE14
    ilo_oe_d  = |(pend_lo_q & en_lo_q); // RULE7 RULE14
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // every register returns to its default while reset is low
      ready_q   <= 1'b0; // RULE1
      rdy_cnt_q <= '0;
      phy_ctl_q <= 1'b0;
      pend_hi_q <= '0;
      pend_lo_q <= '0;
      en_hi_q   <= '0;
      en_lo_q   <= '0;
      phy_n_q   <= 1'b0;
      ihi_oe_q  <= 1'b0;
      ilo_oe_q  <= 1'b0;
    end else if (clk_en_in) begin
      ready_q   <= ready_d;
      rdy_cnt_q <= rdy_cnt_d;
      phy_ctl_q <= phy_ctl_d;
      pend_hi_q <= pend_hi_d;
      pend_lo_q <= pend_lo_d;
      en_hi_q   <= en_hi_d;
      en_lo_q   <= en_lo_d;
      phy_n_q   <= phy_n_d;
      ihi_oe_q  <= ihi_oe_d;
      ilo_oe_q  <= ilo_oe_d;
    end
  end

  assign so_out                       = so_q;
  assign line_transceiver_reset_out_n = phy_n_q;
  // open drain: the data output is tied low, only the enable ever moves
  assign irq_hi_out                   = 1'b0; // RULE8
  assign irq_lo_out                   = 1'b0; // RULE8
  assign irq_hi_oe_out                = ihi_oe_q;
  assign irq_lo_oe_out                = ilo_oe_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_DEFAULTS: assert property ($rose(reset_n_in) |-> !ready_q && en_hi_q == '0 && !phy_ctl_q) // RULE1
    else $error("state not at defaults after reset");
  AST_READY_TIME: assert property (clk_en_in && !ready_q && rdy_cnt_q == RDY_W'(READY_CYCLES - 1)
                                   |=> ready_q) // RULE3
    else $error("reset ready late");
  AST_READY_BIT: assert property (hdr_done && clk_en_in && shreg_q[5:0] == 6'h00 && !pins.si
                                  |=> tx_q[READY_BIT] == $past(ready_q)) // RULE4
    else $error("status bit 7 not reset ready");
  AST_PHY_RESET: assert property (!ready_q ##1 !ready_q |-> !line_transceiver_reset_out_n) // RULE5
    else $error("transceiver reset released before ready");
  AST_IRQ_HI: assert property (clk_en_in && |(pend_hi_q & en_hi_q) |=> irq_hi_oe_out) // RULE6
    else $error("high priority interrupt not asserted");
  AST_IRQ_LO: assert property (clk_en_in && |(pend_lo_q & en_lo_q) |=> irq_lo_oe_out) // RULE7
    else $error("low priority interrupt not asserted");
  AST_OPEN_DRAIN: assert property (irq_hi_oe_out || irq_lo_oe_out |-> !irq_hi_out && !irq_lo_out) // RULE8
    else $error("interrupt driven high");
  AST_SO_BIT: assert property (clk_en_in && st_q == ST_DATA && rd_q && sclk_fall && !pins.cs_n
                               |=> so_out == $past(tx_q[7])) // RULE11
    else $error("read bit not shifted out");
  AST_DESELECT: assert property (clk_en_in && pins.cs_n |=> st_q == ST_IDLE && cnt_q == 4'h0) // RULE13
    else $error("partial frame kept after deselect");
  AST_IRQ_HOLD: assert property (clk_en_in && !(|(pend_hi_q & en_hi_q)) |=> !irq_hi_oe_out) // RULE14
    else $error("interrupt held with nothing pending");

  COV_WRITE: cover property (wr_stb && clk_en_in);
  COV_READ:  cover property (hdr_done && clk_en_in && shreg_q[ADDR_W-1] == CMD_READ);
  COV_READY: cover property ($rose(ready_q));
  COV_IRQ:   cover property ($fell(irq_hi_oe_out));
endmodule

// ==== design/hcsp_pkg.sv ====
// constants, field layout and frame states of the host control serial port
// assumes a single 40 MHz system clock drives the whole block
package hcsp_pkg;
  // timing
  localparam int unsigned CLK_MHZ            = 40;
  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned RESET_MIN_NS       = 300;
  localparam int unsigned RESET_MIN_CYCLES   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_READY_MS     = 5;
  localparam int unsigned RESET_READY_CYCLES = RESET_READY_MS * 1000 * CLK_MHZ;
  // frame layout: command bit, address, data, msb first
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned HDR_BITS  = 8;
  localparam logic        CMD_READ  = 1'b1;
  // register offsets
  localparam logic [6:0] ADDR_RESET_READY_STATUS = 7'h00;
  localparam logic [6:0] ADDR_IRQ_HI_PEND        = 7'h01;
  localparam logic [6:0] ADDR_IRQ_HI_EN          = 7'h02;
  localparam logic [6:0] ADDR_IRQ_LO_PEND        = 7'h03;
  localparam logic [6:0] ADDR_IRQ_LO_EN          = 7'h04;
  // fields of the reset ready status register
  localparam int unsigned READY_BIT   = 7;
  localparam int unsigned PHY_RST_BIT = 0;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_DATA = 2'b11,
    ST_DONE = 2'b10
  } frame_st_t;
endpackage

// ==== design/pin_sync_if.sv ====
// synchronised serial port pins, passed from the pin synchroniser to the port logic
// assumes all members are already in the system clock domain
`timescale 1ns/1ps
interface pin_sync_if;
  logic sclk;
  logic si;
  logic cs_n;
  modport drv (output sclk, output si, output cs_n);
  modport mon (input sclk, input si, input cs_n);
endinterface

// ==== design/pin_sync.sv ====
// two flip-flop synchroniser for the serial clock, data and select pins
// assumes pins are asynchronous to sys_clk_in; first stage feeds only the second
`timescale 1ns/1ps
module pin_sync
  import hcsp_pkg::*;
(
  // clock, reset and enable
  input  wire logic  sys_clk_in,
  input  wire logic  reset_n_in,
  input  wire logic  clk_en_in,
  // raw pins
  input  wire logic  sclk_in,
  input  wire logic  si_in,
  input  wire logic  cs_n_in,
  // synchronised levels
  pin_sync_if.drv    pins
);
  logic [2:0] meta_q;
  logic [2:0] stab_q;

  // select resets high so an idle port reads as deselected
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= 3'h4;
      stab_q <= 3'h4;
    end else if (clk_en_in) begin
      meta_q <= {cs_n_in, si_in, sclk_in};
      stab_q <= meta_q;
    end
  end

  assign pins.sclk = stab_q[0];
  assign pins.si   = stab_q[1];
  assign pins.cs_n = stab_q[2];
endmodule

// ==== testbench/host_mcu_model.sv ====
// host processor model driving the serial microport pins
// assumes the bench clock paces it; half_cyc sets the serial half period
`timescale 1ns/1ps
module host_mcu_model (
  // pacing clock
  input  wire logic clk_in,
  // microport pins
  input  wire logic so_in,
  output logic      sclk_out,
  output logic      si_out,
  output logic      cs_n_out
);
  // six cycles leaves read data settled before each sampling rise
  int half_cyc = 6;
  initial begin
    sclk_out = 1'b0;
    si_out   = 1'b0;
    cs_n_out = 1'b1;
  end
  task automatic pace(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // fewer than 16 bits abandons the frame mid-way
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wd,
                      input int nbits, output logic [7:0] rdat);
    logic [15:0] frm;
    frm  = {rd, adr, wd};
    rdat = 8'h00;
    pace(1);
    cs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si_out = frm[15-i];
      pace(half_cyc);
      sclk_out = 1'b1;
      if (i >= 8) rdat = {rdat[6:0], so_in};
      pace(half_cyc);
      sclk_out = 1'b0;
    end
    pace(half_cyc);
    cs_n_out = 1'b1;
    // a released data line keeps no stale value
    si_out = ~si_out;
    pace(4);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the host control serial port
// assumes a host model on the microport and pull-ups on both interrupt lines
`timescale 1ns/1ps
module tb_top;
  import hcsp_pkg::*;
  localparam int unsigned RDY = 400;
  typedef struct packed {
    logic       rd;
    logic [6:0] adr;
    logic [7:0] dat;
  } row_t;
  logic       sys_clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [7:0] evt_hi     = 8'h00;
  logic [7:0] evt_lo     = 8'h00;
  logic       clk_en     = 1'b1;
  logic       sclk, si, cs_n, so_out, line_rst_n, hi_d, hi_oe, lo_d, lo_oe;
  wire        irq_hi_n   = hi_oe ? hi_d : 1'b1;
  wire        irq_lo_n   = lo_oe ? lo_d : 1'b1;
  int         failures   = 0;
  int         tests_run  = 0;
  logic [7:0] rdat;
  // reads carry the expected byte in dat
  row_t       rows [8]   = '{'{1'b0, 7'h02, 8'hA5}, '{1'b1, 7'h02, 8'hA5},
                             '{1'b0, 7'h04, 8'h3C}, '{1'b1, 7'h04, 8'h3C},
                             '{1'b0, 7'h00, 8'h01}, '{1'b1, 7'h00, 8'h81},
                             '{1'b0, 7'h7F, 8'hFF}, '{1'b1, 7'h7F, 8'h00}};
  always #12.5 sys_clk_in = ~sys_clk_in;
  host_control_serial_port #(.READY_CYCLES(RDY), .EVT_W(8)) i_dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
    .sclk_in(sclk), .si_in(si), .cs_n_in(cs_n), .so_out(so_out),
    .evt_hi_in(evt_hi), .evt_lo_in(evt_lo), .line_transceiver_reset_out_n(line_rst_n),
    .irq_hi_out(hi_d), .irq_hi_oe_out(hi_oe), .irq_lo_out(lo_d), .irq_lo_oe_out(lo_oe));
  host_mcu_model i_host (
    .clk_in(sys_clk_in), .so_in(so_out), .sclk_out(sclk), .si_out(si), .cs_n_out(cs_n));
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic wr(input logic [6:0] adr, input logic [7:0] dat);
    i_host.xfer(1'b0, adr, dat, 16, rdat);
  endtask
  task automatic rd(input logic [6:0] adr);
    i_host.xfer(1'b1, adr, 8'h00, 16, rdat);
  endtask
  // one cycle of events, then room for the two-cycle path to the line
  task automatic pulse(input logic hi, input logic [7:0] v);
    @(posedge sys_clk_in);
    #2;
    evt_hi = hi ? v : 8'h00;
    evt_lo = hi ? 8'h00 : v;
    @(posedge sys_clk_in);
    #2;
    evt_hi = 8'h00;
    evt_lo = 8'h00;
    repeat (2) @(posedge sys_clk_in);
    #2;
  endtask
  task automatic irq_case(input logic hi, input logic [6:0] pend, input logic [6:0] en);
    wr(en, 8'h01);
    pulse(hi, 8'h02);
    check1("masked cause", 1'b1, hi ? irq_hi_n : irq_lo_n);
    pulse(hi, 8'h01);
    check1("line pulled", 1'b0, hi ? irq_hi_n : irq_lo_n);
    rd(pend);
    check8("pending", 8'h03, rdat);
    check1("held after read", 1'b0, hi ? irq_hi_n : irq_lo_n);
    wr(pend, 8'h03);
    check1("line freed", 1'b1, hi ? irq_hi_n : irq_lo_n);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // about 30 frames of roughly 210 cycles each plus the ready wait; double it for margin
  initial begin
    repeat (2 * (30 * 210 + RDY)) @(posedge sys_clk_in);
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge sys_clk_in);
    #2;
    reset_n_in = 1'b1;
    check1("line reset", 1'b0, line_rst_n);
    rd(ADDR_RESET_READY_STATUS);
    check8("status early", 8'h00, rdat);
    // poll readiness rather than wait the full time
    for (int n = 0; n < 10 && rdat[7] !== 1'b1; n++) rd(7'h00);
    check8("status ready", 8'h80, rdat);
    check1("line reset freed", 1'b1, line_rst_n);
    done("reset ready");
    foreach (rows[i]) begin
      i_host.xfer(rows[i].rd, rows[i].adr, rows[i].dat, 16, rdat);
      if (rows[i].rd) check8("read data", rows[i].dat, rdat);
    end
    check1("line reset held", 1'b0, line_rst_n);
    wr(7'h00, 8'h00);
    check1("line reset off", 1'b1, line_rst_n);
    done("register table");
    irq_case(1'b1, ADDR_IRQ_HI_PEND, ADDR_IRQ_HI_EN);
    irq_case(1'b0, ADDR_IRQ_LO_PEND, ADDR_IRQ_LO_EN);
    done("interrupts");
    // last read bit is one, so only the deselect can bring the output back to zero
    wr(7'h02, 8'hA5);
    i_host.xfer(1'b0, 7'h02, 8'hFF, 12, rdat);
    rd(7'h02);
    check8("after abort", 8'hA5, rdat);
    check1("output idle", 1'b0, so_out);
    done("abort");
    wr(ADDR_IRQ_HI_EN, 8'h01);
    // an event that arrives while the enable is low must be lost
    clk_en = 1'b0;
    pulse(1'b1, 8'h01);
    check1("frozen", 1'b1, irq_hi_n);
    clk_en = 1'b1;
    pulse(1'b1, 8'h01);
    @(posedge sys_clk_in);
    #2;
    reset_n_in = 1'b0;
    repeat (RESET_MIN_CYCLES) @(posedge sys_clk_in);
    #2;
    check1("irq in reset", 1'b1, irq_hi_n);
    reset_n_in = 1'b1;
    rd(ADDR_IRQ_HI_EN);
    check8("enable after reset", 8'h00, rdat);
    done("mid reset");
    report_and_stop();
  end
endmodule
